// ### lsc_defines.svh
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

// Register byte offsets on the APB side
`define LSC_OFS_STATUS 12'h000
`define LSC_OFS_COMMAND 12'h004
`define LSC_OFS_CONTROL 12'h008

// Status register field positions
`define LSC_ST_OVERCUR 0
`define LSC_ST_STOPPED 1
`define LSC_ST_CW 2
`define LSC_ST_CCW 3
`define LSC_ST_PARITY 4
`define LSC_ST_OVERTEMP 5
`define LSC_ST_CSUM 6
`define LSC_ST_OVERVOLT 7

// Control register field positions
`define LSC_CTL_STANDBY 0

// Request byte field positions
`define LSC_REQ_CLR_COMM 0
`define LSC_REQ_CLR_DIAG 1
`define LSC_REQ_SOFT 2
`define LSC_REQ_LONG 3
`define LSC_REQ_DUTY_LO 4
`define LSC_REQ_DUTY_HI 5
`define LSC_REQ_ESTOP 6
`define LSC_REQ_RECOVER 7

// Identifier byte field positions
`define LSC_ID_DIR 4
`define LSC_ID_LEN 5
`define LSC_ID_PAR_A 6
`define LSC_ID_PAR_B 7

// Values
`define LSC_HOLD_RST 8'h00
`define LSC_CSUM_GOOD 8'hFF
`define LSC_TARGET_CCW 8'h00
`define LSC_TARGET_CW 8'hFF
`define LSC_DIR_RX 1'b1
`define LSC_LEN_TWO 1'b0

`endif

// ### lsc_pkg.sv
package lsc_pkg;

   // Frame reception progress
   typedef enum logic [1:0] {
      lsc_rx_idle,
      lsc_rx_cmd,
      lsc_rx_req,
      lsc_rx_csum
   } lsc_rx_t;

   // Motor drive mode
   typedef enum logic [1:0] {
      lsc_mot_off,
      lsc_mot_seek,
      lsc_mot_force_cw,
      lsc_mot_force_ccw
   } lsc_motor_t;

endpackage

// ### lsc_servo_rx.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "lsc_defines.svh"

// Summary of operation
// - Own address, receive direction, short length, good parity
// - Foreign or bad identifier: ignore rest of frame
// - Well framed data byte goes to holding register
// - Bad framing discards frame, sets both errors
// - Holding registers clear to zero on reset
// - End-around sum equal all ones commits data
// - Bad sum flags error, official data unchanged
// - New positioning only when target changed or on recovery
// - Target above position: drive A, clockwise
// - Target below position: drive B, counter-clockwise
// - Target reached: both low, stopped flag
// - Recovery with zero target forces counter-clockwise
// - Recovery with full target forces clockwise
// - Forced rotation ignores soft start, keeps duty
// - Request bit zero clears communication errors
// - Request bit one clears protection flags
// - Request bit two enables soft start/stop
// - Request bit three picks long ramp
// - Request bits four, five pick duty limit
// - Request bit six stops motor at once
// - Restart needs new target or recovery; stop beats recovery
// - Recovery resumes unchanged target unless over-current
// - Identifier parity checked, mismatch on own address sets flag
// - Node address from four straps, upper fixed
// - Communication errors hold until clear or standby
module lsc_servo_rx (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Received fields from the frame receiver
   input wire logic i_rx_id_valid,
   input wire logic i_rx_byte_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_start_bit,
   input wire logic i_rx_stop_bit,
   // Address straps (pins)
   input wire logic i_node_addr_bit_a,
   input wire logic i_node_addr_bit_b,
   input wire logic i_node_addr_bit_c,
   input wire logic i_node_addr_bit_d,
   // Position and protection events
   input wire logic [7:0] i_pot_pos,
   input wire logic i_overcur_evt,
   input wire logic i_overtemp_evt,
   input wire logic i_overvolt_evt,
   // Motor and PWM settings
   output logic o_motor_output_a,
   output logic o_motor_output_b,
   output lsc_pkg::lsc_motor_t o_motor_mode,
   output logic o_soft_ramp_en,
   output logic o_ramp_long,
   output logic [1:0] o_duty_sel,
   // Flags
   output logic o_cw_flag,
   output logic o_ccw_flag,
   output logic o_stopped_flag,
   output logic o_parity_err,
   output logic o_csum_err,
   output logic o_overcur_flag,
   output logic o_overtemp_flag,
   output logic o_overvolt_flag
);
   import lsc_pkg::*;

   // Add with the carry folded back into bit zero
   function automatic logic [7:0] add_wrap(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      add_wrap = s[7:0] + {7'h00, s[8]};
   endfunction

   logic [3:0] strap_meta_q;
   logic [3:0] strap_q;
   lsc_rx_t rx_q;
   logic [7:0] id_q;
   logic [7:0] cmd_hold_reg_q;
   logic [7:0] req_hold_reg_q;
   logic [7:0] csum_hold_reg_q;
   logic [7:0] cmd_q;
   logic [7:0] req_q;
   logic commit_q;
   logic [7:0] prev_cmd_q;
   logic standby_q;
   logic par_calc_a;
   logic par_calc_b;
   logic addr_hit;
   logic par_bad;
   logic frame_ok;
   logic [7:0] csum_sum;
   logic commit_d;
   logic csum_fail;
   logic frame_fail;
   logic id_par_fail;
   logic diag_left;
   logic apb_access;
   logic apb_done;
   logic apb_mapped;
   logic [31:0] rd_word;

   // Straps are pins: two flops before use; open pin reads one
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         strap_meta_q <= 4'h0;
         strap_q <= 4'h0;
      end else begin
         strap_meta_q <= {i_node_addr_bit_d, i_node_addr_bit_c, i_node_addr_bit_b, i_node_addr_bit_a};
         strap_q <= strap_meta_q;
      end
   end

   // Identifier checks on the incoming byte
   always_comb begin
      par_calc_a = i_rx_data[0] ^ i_rx_data[1] ^ i_rx_data[2] ^ i_rx_data[4];
      par_calc_b = ~(i_rx_data[1] ^ i_rx_data[3] ^ i_rx_data[4] ^ i_rx_data[5]);
      par_bad = (par_calc_a != i_rx_data[`LSC_ID_PAR_A]) || (par_calc_b != i_rx_data[`LSC_ID_PAR_B]);
      addr_hit = (i_rx_data[3:0] == strap_q);
      frame_ok = i_rx_start_bit == 1'b0 && i_rx_stop_bit == 1'b1;
      id_par_fail = i_rx_id_valid && addr_hit && par_bad;
   end

   // Checksum over identifier, both data bytes and checksum byte
   always_comb begin
      csum_sum = add_wrap(add_wrap(add_wrap(id_q, cmd_hold_reg_q), req_hold_reg_q), i_rx_data);
      commit_d = 1'b0;
      csum_fail = 1'b0;
      frame_fail = 1'b0;
      if (i_rx_byte_valid && rx_q != lsc_rx_idle) begin
         if (!frame_ok) begin
            frame_fail = 1'b1;
         end else if (rx_q == lsc_rx_csum) begin
            commit_d = (csum_sum == `LSC_CSUM_GOOD);
            csum_fail = (csum_sum != `LSC_CSUM_GOOD);
         end
      end
   end

   // Frame sequencing; a new identifier always restarts it
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         rx_q <= lsc_rx_idle;
         id_q <= 8'h00;
         cmd_hold_reg_q <= `LSC_HOLD_RST;
         req_hold_reg_q <= `LSC_HOLD_RST;
         csum_hold_reg_q <= `LSC_HOLD_RST;
      end else if (i_rx_id_valid) begin
         id_q <= i_rx_data;
         if (addr_hit && !par_bad && i_rx_data[`LSC_ID_DIR] == `LSC_DIR_RX
             && i_rx_data[`LSC_ID_LEN] == `LSC_LEN_TWO) begin
            rx_q <= lsc_rx_cmd;
         end else begin
            rx_q <= lsc_rx_idle;
         end
      end else if (i_rx_byte_valid) begin
         case (rx_q)
            lsc_rx_cmd: begin
               if (frame_ok) begin
                  cmd_hold_reg_q <= i_rx_data;
                  rx_q <= lsc_rx_req;
               end else begin
                  rx_q <= lsc_rx_idle;
               end
            end
            lsc_rx_req: begin
               if (frame_ok) begin
                  req_hold_reg_q <= i_rx_data;
                  rx_q <= lsc_rx_csum;
               end else begin
                  rx_q <= lsc_rx_idle;
               end
            end
            lsc_rx_csum: begin
               if (frame_ok) begin
                  csum_hold_reg_q <= i_rx_data;
               end
               rx_q <= lsc_rx_idle;
            end
            default: begin
               rx_q <= lsc_rx_idle;
            end
         endcase
      end
   end

   // Official data only from a frame with a good sum
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         cmd_q <= `LSC_HOLD_RST;
         req_q <= `LSC_HOLD_RST;
         prev_cmd_q <= `LSC_HOLD_RST;
         commit_q <= 1'b0;
      end else begin
         commit_q <= commit_d;
         if (commit_d) begin
            prev_cmd_q <= cmd_q;
            cmd_q <= cmd_hold_reg_q;
            req_q <= req_hold_reg_q;
         end
      end
   end

   // Communication errors; a new error wins over a clear
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_parity_err <= 1'b0;
         o_csum_err <= 1'b0;
      end else begin
         if (id_par_fail || frame_fail) begin
            o_parity_err <= 1'b1;
         end else if (standby_q || (commit_q && req_q[`LSC_REQ_CLR_COMM])) begin
            o_parity_err <= 1'b0;
         end
         if (csum_fail || frame_fail) begin
            o_csum_err <= 1'b1;
         end else if (standby_q || (commit_q && req_q[`LSC_REQ_CLR_COMM])) begin
            o_csum_err <= 1'b0;
         end
      end
   end

   // Protection flags; events win over the clear request
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_overcur_flag <= 1'b0;
         o_overtemp_flag <= 1'b0;
         o_overvolt_flag <= 1'b0;
      end else begin
         if (i_overcur_evt) begin
            o_overcur_flag <= 1'b1;
         end else if (standby_q || (commit_q && req_q[`LSC_REQ_CLR_DIAG])) begin
            o_overcur_flag <= 1'b0;
         end
         if (i_overtemp_evt) begin
            o_overtemp_flag <= 1'b1;
         end else if (standby_q || (commit_q && req_q[`LSC_REQ_CLR_DIAG])) begin
            o_overtemp_flag <= 1'b0;
         end
         if (i_overvolt_evt) begin
            o_overvolt_flag <= 1'b1;
         end else if (standby_q || (commit_q && req_q[`LSC_REQ_CLR_DIAG])) begin
            o_overvolt_flag <= 1'b0;
         end
      end
   end

   // Protection still active after this frame's clear is applied
   always_comb begin
      diag_left = i_overcur_evt || i_overtemp_evt || i_overvolt_evt;
      if (!(commit_q && req_q[`LSC_REQ_CLR_DIAG])) begin
         diag_left = diag_left || o_overcur_flag || o_overtemp_flag || o_overvolt_flag;
      end
   end

   // Motor mode; changes on a commit, a protection event or flag, standby, or a seek reaching its target
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_motor_mode <= lsc_mot_off;
      end else if (standby_q || diag_left) begin
         o_motor_mode <= lsc_mot_off;
      end else if (commit_q) begin
         if (req_q[`LSC_REQ_ESTOP]) begin
            o_motor_mode <= lsc_mot_off;
         end else if (req_q[`LSC_REQ_RECOVER] && !o_overcur_flag && cmd_q == `LSC_TARGET_CCW) begin
            o_motor_mode <= lsc_mot_force_ccw;
         end else if (req_q[`LSC_REQ_RECOVER] && !o_overcur_flag && cmd_q == `LSC_TARGET_CW) begin
            o_motor_mode <= lsc_mot_force_cw;
         end else if (cmd_q != prev_cmd_q) begin
            o_motor_mode <= lsc_mot_seek;
         end else if (req_q[`LSC_REQ_RECOVER] && !o_overcur_flag) begin
            o_motor_mode <= lsc_mot_seek;
         end
      end else if (o_motor_mode == lsc_mot_seek && cmd_q == i_pot_pos) begin
         o_motor_mode <= lsc_mot_off;
      end
   end

   // Bridge outputs and direction flags follow the mode each cycle
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_motor_output_a <= 1'b0;
         o_motor_output_b <= 1'b0;
         o_cw_flag <= 1'b0;
         o_ccw_flag <= 1'b0;
      end else begin
         case (o_motor_mode)
            lsc_mot_seek: begin
               o_motor_output_a <= (cmd_q > i_pot_pos);
               o_motor_output_b <= (cmd_q < i_pot_pos);
               o_cw_flag <= (cmd_q > i_pot_pos);
               o_ccw_flag <= (cmd_q < i_pot_pos);
            end
            lsc_mot_force_cw: begin
               o_motor_output_a <= 1'b1;
               o_motor_output_b <= 1'b0;
               o_cw_flag <= 1'b1;
               o_ccw_flag <= 1'b0;
            end
            lsc_mot_force_ccw: begin
               o_motor_output_a <= 1'b0;
               o_motor_output_b <= 1'b1;
               o_cw_flag <= 1'b0;
               o_ccw_flag <= 1'b1;
            end
            default: begin
               o_motor_output_a <= 1'b0;
               o_motor_output_b <= 1'b0;
               o_cw_flag <= 1'b0;
               o_ccw_flag <= 1'b0;
            end
         endcase
      end
   end

   // Stopped flag after the motor has turned or a seek finds its target reached; reset shows zero
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_stopped_flag <= 1'b0;
      end else if (o_cw_flag || o_ccw_flag) begin
         if (o_motor_mode == lsc_mot_off || (o_motor_mode == lsc_mot_seek && cmd_q == i_pot_pos)) begin
            o_stopped_flag <= 1'b1;
         end else begin
            o_stopped_flag <= 1'b0;
         end
      end else if (o_motor_mode == lsc_mot_seek && cmd_q == i_pot_pos) begin
         // Seek that never turned: new target already reached
         o_stopped_flag <= 1'b1;
      end else if (o_motor_mode != lsc_mot_off) begin
         o_stopped_flag <= 1'b0;
      end
   end

   // Settings for the PWM generator; forced rotation drops the ramp
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_soft_ramp_en <= 1'b0;
         o_ramp_long <= 1'b0;
         o_duty_sel <= 2'h0;
      end else begin
         o_soft_ramp_en <= req_q[`LSC_REQ_SOFT] && o_motor_mode != lsc_mot_force_cw
                           && o_motor_mode != lsc_mot_force_ccw;
         o_ramp_long <= req_q[`LSC_REQ_LONG];
         o_duty_sel <= {req_q[`LSC_REQ_DUTY_HI], req_q[`LSC_REQ_DUTY_LO]};
      end
   end

   // APB decode; one wait state keeps read data registered
   always_comb begin
      apb_access = i_psel && i_penable;
      apb_done = apb_access && o_pready;
      apb_mapped = (i_paddr == `LSC_OFS_STATUS) || (i_paddr == `LSC_OFS_COMMAND)
                   || (i_paddr == `LSC_OFS_CONTROL);
      rd_word = 32'h0000_0000;
      case (i_paddr)
         `LSC_OFS_STATUS: begin
            rd_word = {24'h00_0000, o_overvolt_flag, o_csum_err, o_overtemp_flag, o_parity_err,
                       o_ccw_flag, o_cw_flag, o_stopped_flag, o_overcur_flag};
         end
         `LSC_OFS_COMMAND: begin
            rd_word = {8'h00, i_pot_pos, req_q, cmd_q};
         end
         `LSC_OFS_CONTROL: begin
            rd_word = {31'h0000_0000, standby_q};
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // APB answer; unmapped addresses read zero with an error
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (apb_access && !o_pready) begin
         o_pready <= 1'b1;
         o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
         o_pslverr <= !apb_mapped;
      end else begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
   end

   // Standby control; write lands on the completing edge only
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         standby_q <= 1'b0;
      end else if (apb_done && i_pwrite && i_paddr == `LSC_OFS_CONTROL) begin
         standby_q <= i_pwdata[`LSC_CTL_STANDBY];
      end
   end

endmodule

// ### lsc_servo_rx_props.sv
`timescale 1ns/1ns
module lsc_servo_rx_props (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Bus and receive strobes
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_rx_byte_valid,
   input wire logic i_overcur_evt,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [31:0] o_prdata,
   // Motor, settings and flags
   input wire logic o_motor_output_a,
   input wire logic o_motor_output_b,
   input wire lsc_pkg::lsc_motor_t o_motor_mode,
   input wire logic o_soft_ramp_en,
   input wire logic [1:0] o_duty_sel,
   input wire logic o_cw_flag,
   input wire logic o_ccw_flag,
   input wire logic o_stopped_flag,
   input wire logic o_parity_err,
   input wire logic o_csum_err,
   input wire logic o_overcur_flag
);
   import lsc_pkg::*;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // Bridge sides and direction flags never conflict
   a_bridge_safe: assert property (!(o_motor_output_a && o_motor_output_b)) else $error("both sides on");
   a_dir_pair: assert property (!(o_cw_flag && o_ccw_flag)) else $error("both directions");
   a_stop_flags: assert property (o_stopped_flag [*3] |-> !o_cw_flag && !o_ccw_flag) else $error("stop dir");
   // Reset clears outputs, checked through the reset itself
   a_rst_clear: assert property (disable iff (1'b0) !i_nrst |=> !o_motor_output_a && !o_motor_output_b
      && !o_csum_err && !o_parity_err && o_motor_mode == lsc_mot_off) else $error("reset value");
   a_err_clear: assert property ($fell(o_csum_err) |-> !o_parity_err) else $error("errors split");
   // Bus answer one cycle into the access phase
   a_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late ready");
   a_slverr_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000) else $error("err data");
   // Duty select only moves after a received byte
   a_commit_cause: assert property ($changed(o_duty_sel) |-> $past(i_rx_byte_valid, 1) || $past(i_rx_byte_valid, 2)
      || $past(i_rx_byte_valid, 3)) else $error("duty moved alone");
   a_prot_set: assert property (i_overcur_evt |=> o_overcur_flag) else $error("overcur missed");
   a_prot_stop: assert property (o_overcur_flag [*4] |-> !o_motor_output_a && !o_motor_output_b)
      else $error("drive on fault");
   a_force_soft: assert property ((o_motor_mode inside {lsc_mot_force_cw, lsc_mot_force_ccw}) && $stable(o_motor_mode)
      |-> !o_soft_ramp_en) else $error("soft in forced");
endmodule
bind lsc_servo_rx lsc_servo_rx_props u_props (.*);

// ### lsc_lin_master.sv
`timescale 1ns/1ns
module lsc_lin_master (
   // Clock
   input wire logic i_ref_clk,
   // Received fields toward the block
   output logic o_id_valid,
   output logic o_byte_valid,
   output logic [7:0] o_data,
   output logic o_start_bit,
   output logic o_stop_bit
);
   // Idle shows broken framing so a stale byte never looks valid
   initial begin
      o_id_valid = 1'b0;
      o_byte_valid = 1'b0;
      o_data = 8'hA5;
      o_start_bit = 1'b1;
      o_stop_bit = 1'b0;
   end
   // One field, then an idle cycle
   task automatic put(input logic [7:0] d, input logic is_id, input logic bad);
      @(posedge i_ref_clk);
      o_id_valid <= is_id;
      o_byte_valid <= !is_id;
      o_data <= d;
      o_start_bit <= 1'b0;
      o_stop_bit <= !bad;
      @(posedge i_ref_clk);
      o_id_valid <= 1'b0;
      o_byte_valid <= 1'b0;
      o_data <= ~d;
      o_start_bit <= 1'b1;
      o_stop_bit <= 1'b0;
   endtask
   // Whole frame; flip corrupts the sum, bad breaks the request stop bit
   task automatic send(input logic [7:0] id, cmd, req, flip, input logic bad);
      logic [8:0] s;
      s = 9'(id) + 9'(cmd);
      s = 9'(s[7:0]) + 9'(s[8]);
      s = 9'(s[7:0]) + 9'(req);
      s = 9'(s[7:0]) + 9'(s[8]);
      put(id, 1'b1, 1'b0);
      put(cmd, 1'b0, 1'b0);
      put(req, 1'b0, bad);
      put(~s[7:0] ^ flip, 1'b0, 1'b0);
   endtask
endmodule

// ### lsc_servo_rx_tb.sv
`timescale 1ns/1ns
module lsc_servo_rx_tb;
   import lsc_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata;
   logic o_pready, o_pslverr, i_rx_id_valid, i_rx_byte_valid, i_rx_start_bit, i_rx_stop_bit;
   logic [7:0] i_rx_data, i_pot_pos = 8'h00;
   // Node five strapped: a and c open
   logic i_node_addr_bit_a = 1'b1, i_node_addr_bit_b = 1'b0, i_node_addr_bit_c = 1'b1, i_node_addr_bit_d = 1'b0;
   logic i_overcur_evt = 1'b0, i_overtemp_evt = 1'b0, i_overvolt_evt = 1'b0;
   logic o_motor_output_a, o_motor_output_b, o_soft_ramp_en, o_ramp_long, o_cw_flag, o_ccw_flag;
   logic o_stopped_flag, o_parity_err, o_csum_err, o_overcur_flag, o_overtemp_flag, o_overvolt_flag;
   logic [1:0] o_duty_sel;
   lsc_motor_t o_motor_mode;
   int miscompares = 0;
   int samples_checked = 0;
   // Block and far-side master
   lsc_servo_rx u_dut (.*);
   lsc_lin_master u_lin (.i_ref_clk(i_ref_clk), .o_id_valid(i_rx_id_valid), .o_byte_valid(i_rx_byte_valid),
      .o_data(i_rx_data), .o_start_bit(i_rx_start_bit), .o_stop_bit(i_rx_stop_bit));
   // Clock
   always #10 i_ref_clk = ~i_ref_clk;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Order: a, b, cw, ccw, stopped
   task automatic mot(input logic [4:0] e);
      chk("motor", {27'h0, e}, {27'h0, o_motor_output_a, o_motor_output_b, o_cw_flag, o_ccw_flag, o_stopped_flag});
   endtask
   task automatic errs(input logic [1:0] e);
      chk("errors", {30'h0, e}, {30'h0, o_parity_err, o_csum_err});
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // Idle edge so a following call never reassigns psel in this step
      @(posedge i_ref_clk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk("read", e, rd);
      chk("slverr", 32'h0, {31'h0, er});
   endtask
   // Frame then settle: commit, mode, outputs, stopped flag
   task automatic frm(input logic [7:0] id, c, r, x = 8'h00, input logic bad = 1'b0);
      u_lin.send(id, c, r, x, bad);
      repeat (6) @(posedge i_ref_clk);
   endtask
   task automatic t_seek();
      i_pot_pos <= 8'h40;
      frm(8'h55, 8'h40, 8'h00);
      mot(5'b00001);
      frm(8'h55, 8'h80, 8'h00);
      mot(5'b10100);
      rdchk(12'h004, 32'h0040_0080);
      i_pot_pos <= 8'h80;
      repeat (6) @(posedge i_ref_clk);
      mot(5'b00001);
      frm(8'h55, 8'h20, 8'h3C);
      mot(5'b01010);
      chk("ramp", 32'h3, {30'h0, o_soft_ramp_en, o_ramp_long});
      for (int k = 0; k < 4; k++) begin
         frm(8'h55, 8'h20, 8'(k << 4));
         chk("duty", 32'(k), {30'h0, o_duty_sel});
      end
   endtask
   task automatic t_stop();
      frm(8'h55, 8'h20, 8'h40);
      mot(5'b00001);
      frm(8'h55, 8'h20, 8'h00);
      mot(5'b00001);
      frm(8'h55, 8'h20, 8'hC0);
      mot(5'b00001);
      frm(8'h55, 8'h20, 8'h80);
      mot(5'b01010);
      i_pot_pos <= 8'h20;
      repeat (6) @(posedge i_ref_clk);
      mot(5'b00001);
   endtask
   task automatic t_errs();
      logic [7:0] ids [3] = '{8'h14, 8'hF5, 8'h85};
      foreach (ids[i]) begin
         frm(ids[i], 8'h33, 8'h00, 8'h01);
         errs(2'b00);
      end
      rdchk(12'h004, 32'h0020_8020);
      frm(8'hD5, 8'h33, 8'h00, 8'h01);
      errs(2'b10);
      frm(8'h55, 8'h20, 8'h01);
      errs(2'b00);
      frm(8'h55, 8'h44, 8'h00, 8'h01);
      errs(2'b01);
      rdchk(12'h004, 32'h0020_0120);
      frm(8'h55, 8'h20, 8'h00, 8'h00, 1'b1);
      errs(2'b11);
      frm(8'h55, 8'h20, 8'h00);
      errs(2'b11);
      frm(8'h55, 8'h20, 8'h01);
      errs(2'b00);
   endtask
   task automatic t_force();
      i_pot_pos <= 8'h00;
      frm(8'h55, 8'h00, 8'h80);
      mot(5'b01010);
      chk("mode", 32'(lsc_mot_force_ccw), 32'(o_motor_mode));
      i_pot_pos <= 8'hFF;
      frm(8'h55, 8'hFF, 8'h94);
      mot(5'b10100);
      chk("soft", 32'h0, {31'h0, o_soft_ramp_en});
      chk("duty", 32'h1, {30'h0, o_duty_sel});
      i_overcur_evt <= 1'b1;
      i_overtemp_evt <= 1'b1;
      i_overvolt_evt <= 1'b1;
      @(posedge i_ref_clk);
      i_overcur_evt <= 1'b0;
      i_overtemp_evt <= 1'b0;
      i_overvolt_evt <= 1'b0;
      repeat (6) @(posedge i_ref_clk);
      chk("prot", 32'h7, {29'h0, o_overcur_flag, o_overtemp_flag, o_overvolt_flag});
      chk("bridge", 32'h0, {30'h0, o_motor_output_a, o_motor_output_b});
      frm(8'h55, 8'h40, 8'h02);
      chk("prot", 32'h0, {29'h0, o_overcur_flag, o_overtemp_flag, o_overvolt_flag});
      mot(5'b01010);
      frm(8'h55, 8'h40, 8'h40);
      mot(5'b00001);
   endtask
   task automatic t_regs();
      logic [31:0] rd;
      logic er;
      rdchk(12'h000, 32'h0000_0002);
      rdchk(12'h004, 32'h00FF_4040);
      apb(1'b0, 12'h00C, 32'h0, rd, er);
      chk("unmapped err", 32'h1, {31'h0, er}); // refused read
      chk("unmapped data", 32'h0, rd); // refused read
      apb(1'b1, 12'h008, 32'h1, rd, er);
      rdchk(12'h008, 32'h1);
      apb(1'b1, 12'h008, 32'h0, rd, er);
      rdchk(12'h008, 32'h0);
   endtask
   task automatic end_sim();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      mot(5'b00000);
      rdchk(12'h004, 32'h0);
      t_seek();
      t_stop();
      t_errs();
      t_force();
      t_regs();
      end_sim();
   end
   // Watchdog well beyond the few hundred cycles needed
   initial begin
      #1000000;
      miscompares++;
      end_sim();
   end
endmodule
